// >>> deir_chk.sv
/*
  Checker for deir_router: bus handshake, read masks and pin release.
  Assumes it is bound to the router and sees only its ports.
*/
`timescale 1ns/100ps
module deir_chk
(
  input wire        i_ref_clk,
  input wire        i_sys_rst,
  input wire [9:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire        o_interrupt_pin_a_n,
  input wire        o_interrupt_pin_b_n
);
  wire [7:0] idx = i_avs_address[9:2];
  wire       acc = !o_avs_waitrequest;
  wire       wa  = acc && i_avs_write;
  wire       ra  = acc && i_avs_read;

  function [7:0] rmask(input [7:0] x);
    case (x)
      8'h20, 8'h24, 8'h28: rmask = 8'h1f;
      8'h23, 8'h27, 8'h2b: rmask = 8'h33;
      8'h21, 8'h22, 8'h25, 8'h26, 8'h29, 8'h2a: rmask = 8'h09;
      8'h2c: rmask = 8'h01;
      default: rmask = 8'h00;
    endcase
  endfunction

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  property p_ack_next;
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> acc;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acked");
  property p_wait_one;
    acc |=> o_avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("ack too long");
  property p_no_req;
    !(i_avs_read || i_avs_write) |=> o_avs_waitrequest;
  endproperty
  a_no_req: assert property (p_no_req) else $error("ack without request");
  property p_hi_zero;
    ra |-> o_avs_readdata[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  property p_rd_mask;
    ra |-> (o_avs_readdata[7:0] & ~rmask(idx)) == 8'h00;
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("reserved bit set");
  // a latched pin is only released by some register write
  property p_rise_a;
    $rose(o_interrupt_pin_a_n) |-> $past(wa, 2) || $past(wa, 3);
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("pin a freed alone");
  property p_rise_b;
    $rose(o_interrupt_pin_b_n) |-> $past(wa, 2) || $past(wa, 3);
  endproperty
  a_rise_b: assert property (p_rise_b) else $error("pin b freed alone");
  property p_summary;
    ra && idx == 8'h2c && !(o_interrupt_pin_a_n && o_interrupt_pin_b_n)
      |-> o_avs_readdata[0];
  endproperty
  a_summary: assert property (p_summary) else $error("summary low");

  c_pin_a: cover property (!o_interrupt_pin_a_n);
  c_pin_b: cover property (!o_interrupt_pin_b_n);
  c_sum: cover property (ra && idx == 8'h2c && o_avs_readdata[0]);
endmodule

bind deir_router deir_chk u_chk
(
  .i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst),
  .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest),
  .o_interrupt_pin_a_n(o_interrupt_pin_a_n),
  .o_interrupt_pin_b_n(o_interrupt_pin_b_n)
);

// >>> deir_flag_bank.v
/*
  One 8-bit event status register: live when its enable is clear,
  latched and write-one-to-clear when set, routed to one of two pins.
  Assumes synchronised live inputs and one-cycle clear strobes.
*/
`timescale 1ns/100ps
`include "deir_map.vh"
module deir_flag_bank
#(
  parameter [7:0] MASK = 8'hff
)
(
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire [7:0] i_live,
  input  wire [7:0] i_enable,
  input  wire [7:0] i_pin_sel,
  input  wire [7:0] i_clear,
  input  wire       i_clear_all,
  output wire [7:0] o_flags,
  output wire       o_req_a,
  output wire       o_req_b
);

  reg  [7:0] flag_r;
  wire [7:0] clr;
  wire [7:0] held;
  wire [7:0] flag_nxt;

  assign clr = i_clear | {8{i_clear_all}};
  // set wins over a clear landing in the same cycle
  assign held = i_live | (flag_r & ~clr);
  assign flag_nxt = ((i_enable & held) | (~i_enable & i_live)) & MASK;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      flag_r <= `DEIR_RST_REG;
    else
      flag_r <= flag_nxt;
  end

  assign o_flags = flag_r;
  // only enabled flags may reach a pin
  assign o_req_a = |(flag_r & i_enable & ~i_pin_sel & MASK);
  assign o_req_b = |(flag_r & i_enable & i_pin_sel & MASK);

endmodule

// >>> deir_host_mon.sv
/*
  Host side of the two interrupt pins: counts each assertion.
  Assumes active-low pins; servicing is done by the bench over the bus.
*/
`timescale 1ns/100ps
module deir_host_mon
(
  input  wire    i_pin_a_n,
  input  wire    i_pin_b_n,
  output integer o_falls_a,
  output integer o_falls_b
);
  initial
  begin
    o_falls_a = 0;
    o_falls_b = 0;
  end
  always @(negedge i_pin_a_n)
    o_falls_a = o_falls_a + 1;
  always @(negedge i_pin_b_n)
    o_falls_b = o_falls_b + 1;
endmodule

// >>> deir_map.vh
/*
  Register map, field masks and reset values of the DAC event interrupt
  router. Assumes word-aligned Avalon-MM byte addressing: the byte address
  of a register is four times its index.
*/
// What this block does
// - real-channel pattern error flag sits in link status bit 0
// - converter 0 calibration complete flag in bit 3 of index 0x025
// - converter 0 amplifier protection flag in bit 0 of index 0x025
// - converter 1 calibration complete flag in bit 3 of index 0x026
// - converter 1 amplifier protection flag in bit 0 of index 0x026
// - DLL lock lost flag in bit 5 of index 0x027
// - DLL lock achieved flag in bit 4 of index 0x027
// - PLL lock lost flag in bit 1 of index 0x027
// - PLL lock achieved flag in bit 0 of index 0x027
// - a latched enabled flag pulls its selected interrupt pin low
// - latched flag clears only on writing one; zero leaves it
// - link pin select holds five select bits, bits 4 down to 0
// - converter 0 pin select uses bits 3 and 0; 2:1 reserved
// - converter 1 pin select uses bits 3 and 0; 2:1 reserved
// - select zero routes to pin a, select one to pin b
// - events with enable clear never drive either pin
// - one read/write enable per event, reset zero, PLL lost at 0x023
// - summary reads OR of all flags; writing one clears all latches
`ifndef DEIR_MAP_VH
`define DEIR_MAP_VH

`define DEIR_IDX_LINK_EN     8'h20
`define DEIR_IDX_CONV0_EN    8'h21
`define DEIR_IDX_CONV1_EN    8'h22
`define DEIR_IDX_CLK_EN      8'h23
`define DEIR_IDX_LINK_FLAGS  8'h24
`define DEIR_IDX_CONV0_FLAGS 8'h25
`define DEIR_IDX_CONV1_FLAGS 8'h26
`define DEIR_IDX_CLK_FLAGS   8'h27
`define DEIR_IDX_LINK_SEL    8'h28
`define DEIR_IDX_CONV0_SEL   8'h29
`define DEIR_IDX_CONV1_SEL   8'h2a
`define DEIR_IDX_CLK_SEL     8'h2b
`define DEIR_IDX_SUMMARY     8'h2c

`define DEIR_MASK_LINK       8'h1f
`define DEIR_MASK_CONV       8'h09
`define DEIR_MASK_CLK        8'h33

`define DEIR_BIT_REAL_PAT    0
`define DEIR_BIT_CAL_DONE    3
`define DEIR_BIT_AMP_PROT    0
`define DEIR_BIT_DLL_LOST    5
`define DEIR_BIT_DLL_LOCK    4
`define DEIR_BIT_PLL_LOST    1
`define DEIR_BIT_PLL_LOCK    0
`define DEIR_BIT_SUMMARY     0

`define DEIR_RST_REG         8'h00
`define DEIR_EVENT_COUNT     13

`endif

// >>> deir_router.v
/*
  DAC event interrupt router: event status, enable and pin select
  registers behind an Avalon-MM slave with waitrequest, driving two
  active-low interrupt pins.
  Assumes event inputs are asynchronous levels and the bus master keeps
  its request steady until it samples waitrequest low.
*/
`timescale 1ns/100ps
`include "deir_map.vh"
module deir_router
(
  input  wire        i_ref_clk,
  input  wire        i_sys_rst,
  input  wire [9:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  input  wire        i_real_pattern_error,
  input  wire        i_imag_pattern_error,
  input  wire        i_lane_buffer_error,
  input  wire        i_link_not_ready,
  input  wire        i_sync_jitter_error,
  input  wire        i_conv0_cal_complete,
  input  wire        i_conv0_amp_protect,
  input  wire        i_conv1_cal_complete,
  input  wire        i_conv1_amp_protect,
  input  wire        i_dll_lock_lost,
  input  wire        i_dll_locked,
  input  wire        i_pll_lock_lost,
  input  wire        i_pll_locked,
  output wire        o_interrupt_pin_a_n,
  output wire        o_interrupt_pin_b_n
);

  function hit;
    input [9:0] addr;
    input [7:0] idx;
  begin
    hit = (addr[9:2] == idx);
  end
  endfunction

  // enable registers
  reg  [7:0]  link_en_r;
  reg  [7:0]  conv0_en_r;
  reg  [7:0]  conv1_en_r;
  reg  [7:0]  clk_en_r;
  // pin select registers
  reg  [7:0]  link_sel_r;
  reg  [7:0]  conv0_sel_r;
  reg  [7:0]  conv1_sel_r;
  reg  [7:0]  clk_sel_r;
  // bus and pin state
  reg         waitrequest_r;
  reg  [31:0] readdata_r;
  reg  [7:0]  rd_nxt;
  reg         pin_a_n_r;
  reg         pin_b_n_r;

  wire [12:0] ev_async;
  wire [12:0] ev_sync;
  wire [7:0]  link_live;
  wire [7:0]  conv0_live;
  wire [7:0]  conv1_live;
  wire [7:0]  clk_live;
  wire [7:0]  link_flags;
  wire [7:0]  conv0_flags;
  wire [7:0]  conv1_flags;
  wire [7:0]  clk_flags;
  wire [3:0]  req_a;
  wire [3:0]  req_b;
  wire        req_seen;
  wire        wr_go;
  wire [7:0]  wr_data;
  wire        summary;
  wire        clear_all;

  assign ev_async = {i_pll_locked,
                     i_pll_lock_lost,
                     i_dll_locked,
                     i_dll_lock_lost,
                     i_conv1_amp_protect,
                     i_conv1_cal_complete,
                     i_conv0_amp_protect,
                     i_conv0_cal_complete,
                     i_sync_jitter_error,
                     i_link_not_ready,
                     i_lane_buffer_error,
                     i_imag_pattern_error,
                     i_real_pattern_error};

  // event levels come from other clock domains
  deir_sync2
  #(
    .W (`DEIR_EVENT_COUNT)
  )
  u_sync
  (
    .i_clk   (i_ref_clk),
    .i_rst   (i_sys_rst),
    .i_async (ev_async),
    .o_sync  (ev_sync)
  );

  assign link_live = {3'h0,
                      ev_sync[4],
                      ev_sync[3],
                      ev_sync[2],
                      ev_sync[1],
                      ev_sync[0]};

  assign conv0_live = {4'h0,
                       ev_sync[5],
                       2'h0,
                       ev_sync[6]};

  assign conv1_live = {4'h0,
                       ev_sync[7],
                       2'h0,
                       ev_sync[8]};

  assign clk_live = {2'h0,
                     ev_sync[9],
                     ev_sync[10],
                     2'h0,
                     ev_sync[11],
                     ev_sync[12]};

  // bus handshake: one wait cycle, answer on the second edge
  assign req_seen = i_avs_read | i_avs_write;
  assign wr_go = i_avs_write & ~waitrequest_r & i_avs_byteenable[0];
  assign wr_data = i_avs_writedata[7:0];

  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      waitrequest_r <= 1'b1;
    else
      waitrequest_r <= ~(req_seen & waitrequest_r);
  end

  // summary write clears every latch at once
  assign clear_all = wr_go &
                     hit(i_avs_address, `DEIR_IDX_SUMMARY) &
                     wr_data[`DEIR_BIT_SUMMARY];

  deir_flag_bank
  #(
    .MASK (`DEIR_MASK_LINK)
  )
  u_link_bank
  (
    .i_clk       (i_ref_clk),
    .i_rst       (i_sys_rst),
    .i_live      (link_live),
    .i_enable    (link_en_r),
    .i_pin_sel   (link_sel_r),
    .i_clear     (wr_data &
                  {8{wr_go & hit(i_avs_address,
                                 `DEIR_IDX_LINK_FLAGS)}}),
    .i_clear_all (clear_all),
    .o_flags     (link_flags),
    .o_req_a     (req_a[0]),
    .o_req_b     (req_b[0])
  );

  deir_flag_bank
  #(
    .MASK (`DEIR_MASK_CONV)
  )
  u_conv0_bank
  (
    .i_clk       (i_ref_clk),
    .i_rst       (i_sys_rst),
    .i_live      (conv0_live),
    .i_enable    (conv0_en_r),
    .i_pin_sel   (conv0_sel_r),
    .i_clear     (wr_data &
                  {8{wr_go & hit(i_avs_address,
                                 `DEIR_IDX_CONV0_FLAGS)}}),
    .i_clear_all (clear_all),
    .o_flags     (conv0_flags),
    .o_req_a     (req_a[1]),
    .o_req_b     (req_b[1])
  );

  deir_flag_bank
  #(
    .MASK (`DEIR_MASK_CONV)
  )
  u_conv1_bank
  (
    .i_clk       (i_ref_clk),
    .i_rst       (i_sys_rst),
    .i_live      (conv1_live),
    .i_enable    (conv1_en_r),
    .i_pin_sel   (conv1_sel_r),
    .i_clear     (wr_data &
                  {8{wr_go & hit(i_avs_address,
                                 `DEIR_IDX_CONV1_FLAGS)}}),
    .i_clear_all (clear_all),
    .o_flags     (conv1_flags),
    .o_req_a     (req_a[2]),
    .o_req_b     (req_b[2])
  );

  deir_flag_bank
  #(
    .MASK (`DEIR_MASK_CLK)
  )
  u_clk_bank
  (
    .i_clk       (i_ref_clk),
    .i_rst       (i_sys_rst),
    .i_live      (clk_live),
    .i_enable    (clk_en_r),
    .i_pin_sel   (clk_sel_r),
    .i_clear     (wr_data &
                  {8{wr_go & hit(i_avs_address,
                                 `DEIR_IDX_CLK_FLAGS)}}),
    .i_clear_all (clear_all),
    .o_flags     (clk_flags),
    .o_req_a     (req_a[3]),
    .o_req_b     (req_b[3])
  );

  // includes live bits shown while an enable is clear
  assign summary = |{link_flags, conv0_flags, conv1_flags,
                     clk_flags};

  // enable and select registers; reserved bits never store
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      link_en_r   <= `DEIR_RST_REG;
      conv0_en_r  <= `DEIR_RST_REG;
      conv1_en_r  <= `DEIR_RST_REG;
      clk_en_r    <= `DEIR_RST_REG;
      link_sel_r  <= `DEIR_RST_REG;
      conv0_sel_r <= `DEIR_RST_REG;
      conv1_sel_r <= `DEIR_RST_REG;
      clk_sel_r   <= `DEIR_RST_REG;
    end
    else if (wr_go)
    begin
      if (hit(i_avs_address, `DEIR_IDX_LINK_EN))
        link_en_r <= wr_data & `DEIR_MASK_LINK;
      else if (hit(i_avs_address, `DEIR_IDX_CONV0_EN))
        conv0_en_r <= wr_data & `DEIR_MASK_CONV;
      else if (hit(i_avs_address, `DEIR_IDX_CONV1_EN))
        conv1_en_r <= wr_data & `DEIR_MASK_CONV;
      else if (hit(i_avs_address, `DEIR_IDX_CLK_EN))
        clk_en_r <= wr_data & `DEIR_MASK_CLK;
      else if (hit(i_avs_address, `DEIR_IDX_LINK_SEL))
        link_sel_r <= wr_data & `DEIR_MASK_LINK;
      else if (hit(i_avs_address, `DEIR_IDX_CONV0_SEL))
        conv0_sel_r <= wr_data & `DEIR_MASK_CONV;
      else if (hit(i_avs_address, `DEIR_IDX_CONV1_SEL))
        conv1_sel_r <= wr_data & `DEIR_MASK_CONV;
      else if (hit(i_avs_address, `DEIR_IDX_CLK_SEL))
        clk_sel_r <= wr_data & `DEIR_MASK_CLK;
    end
  end

  // read decode; unmapped indices read zero
  always @*
  begin
    if (hit(i_avs_address, `DEIR_IDX_LINK_EN))
      rd_nxt = link_en_r;
    else if (hit(i_avs_address, `DEIR_IDX_CONV0_EN))
      rd_nxt = conv0_en_r;
    else if (hit(i_avs_address, `DEIR_IDX_CONV1_EN))
      rd_nxt = conv1_en_r;
    else if (hit(i_avs_address, `DEIR_IDX_CLK_EN))
      rd_nxt = clk_en_r;
    else if (hit(i_avs_address, `DEIR_IDX_LINK_FLAGS))
      rd_nxt = link_flags;
    else if (hit(i_avs_address, `DEIR_IDX_CONV0_FLAGS))
      rd_nxt = conv0_flags;
    else if (hit(i_avs_address, `DEIR_IDX_CONV1_FLAGS))
      rd_nxt = conv1_flags;
    else if (hit(i_avs_address, `DEIR_IDX_CLK_FLAGS))
      rd_nxt = clk_flags;
    else if (hit(i_avs_address, `DEIR_IDX_LINK_SEL))
      rd_nxt = link_sel_r;
    else if (hit(i_avs_address, `DEIR_IDX_CONV0_SEL))
      rd_nxt = conv0_sel_r;
    else if (hit(i_avs_address, `DEIR_IDX_CONV1_SEL))
      rd_nxt = conv1_sel_r;
    else if (hit(i_avs_address, `DEIR_IDX_CLK_SEL))
      rd_nxt = clk_sel_r;
    else if (hit(i_avs_address, `DEIR_IDX_SUMMARY))
      rd_nxt = {7'h00, summary};
    else
      rd_nxt = 8'h00;
  end

  // data is captured in the wait cycle so it stands when waitrequest drops
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      readdata_r <= 32'h0000_0000;
    else if (i_avs_read & waitrequest_r)
      readdata_r <= {24'h00_0000, rd_nxt};
  end

  // pins are an OR over all routed requests, so a shared pin
  // releases only when the last latched event is cleared
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pin_a_n_r <= 1'b1;
      pin_b_n_r <= 1'b1;
    end
    else
    begin
      pin_a_n_r <= ~(|req_a);
      pin_b_n_r <= ~(|req_b);
    end
  end

  assign o_avs_readdata    = readdata_r;
  assign o_avs_waitrequest = waitrequest_r;
  assign o_interrupt_pin_a_n = pin_a_n_r;
  assign o_interrupt_pin_b_n = pin_b_n_r;

endmodule

// >>> deir_sync2.v
/*
  Two-flop synchroniser for a vector of independent level inputs.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/100ps
module deir_sync2
#(
  parameter W = 13
)
(
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;

endmodule

// >>> tb_top.sv
/*
  Random register and event traffic checked against a bench model.
  Assumes one wait cycle per access and pins settled six edges later.
*/
`timescale 1ns/100ps
module tb_top;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg  [9:0]  adr = 10'h0;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg  [3:0]  be = 4'h0;
  reg  [12:0] ev = 13'h0;
  wire [31:0] rdata;
  wire        wreq;
  wire        pa_n;
  wire        pb_n;
  integer     falls_a;
  integer     falls_b;
  integer     err_count = 0;
  integer     comparisons = 0;
  integer     seed = 52;
  integer     i;
  integer     g;
  reg  [7:0]  en [0:3];
  reg  [7:0]  sel [0:3];
  reg  [7:0]  lat [0:3];
  reg  [31:0] q;
  reg  [31:0] r;

  always #50 clk = ~clk;

  deir_router u_dut
  (
    .i_ref_clk(clk),
    .i_sys_rst(rst),
    .i_avs_address(adr),
    .i_avs_read(rd),
    .i_avs_write(wr),
    .i_avs_writedata(wd),
    .i_avs_byteenable(be),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq),
    .i_real_pattern_error(ev[0]),
    .i_imag_pattern_error(ev[1]),
    .i_lane_buffer_error(ev[2]),
    .i_link_not_ready(ev[3]),
    .i_sync_jitter_error(ev[4]),
    .i_conv0_cal_complete(ev[5]),
    .i_conv0_amp_protect(ev[6]),
    .i_conv1_cal_complete(ev[7]),
    .i_conv1_amp_protect(ev[8]),
    .i_dll_lock_lost(ev[9]),
    .i_dll_locked(ev[10]),
    .i_pll_lock_lost(ev[11]),
    .i_pll_locked(ev[12]),
    .o_interrupt_pin_a_n(pa_n),
    .o_interrupt_pin_b_n(pb_n)
  );

  deir_host_mon u_host
  (
    .i_pin_a_n(pa_n),
    .i_pin_b_n(pb_n),
    .o_falls_a(falls_a),
    .o_falls_b(falls_b)
  );

  function [7:0] live(input integer k);
    case (k)
      0: live = {3'h0, ev[4:0]};
      1: live = {4'h0, ev[5], 2'h0, ev[6]};
      2: live = {4'h0, ev[7], 2'h0, ev[8]};
      default: live = {2'h0, ev[9], ev[10], 2'h0, ev[11], ev[12]};
    endcase
  endfunction

  function [7:0] msk(input integer k);
    msk = k == 0 ? 8'h1f : (k == 3 ? 8'h33 : 8'h09);
  endfunction

  function [7:0] shown(input integer k);
    shown = (lat[k] & en[k]) | (live(k) & ~en[k]);
  endfunction

  function [7:0] exp_rd(input [7:0] x);
    case (x[7:2])
      6'h08: exp_rd = en[x[1:0]];
      6'h09: exp_rd = shown(x[1:0]);
      6'h0a: exp_rd = sel[x[1:0]];
      6'h0b: exp_rd = {7'h0, x[1:0] == 2'd0 &&
                       |{shown(0), shown(1), shown(2), shown(3)}};
      default: exp_rd = 8'h00;
    endcase
  endfunction

  task test_done;
    begin
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("ERROR %0t: saw %h expected %h", $time, got, exp);
      end
    end
  endtask

  // request held until waitrequest is seen low, released just after
  task bus(input w, input [7:0] x, input [7:0] d, input b);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= {x, 2'b00};
      wd <= {24'h0, d};
      be <= {3'h0, b};
      @(posedge clk);
      while (wreq !== 1'b0 && n < 20)
      begin
        @(posedge clk);
        n = n + 1;
      end
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 20)
      begin
        err_count = err_count + 1;
        test_done;
      end
    end
  endtask

  task mwr(input [7:0] x, input [7:0] d);
    case (x[7:2])
      6'h08: en[x[1:0]] = d & msk(x[1:0]);
      6'h09: lat[x[1:0]] = lat[x[1:0]] & ~d;
      6'h0a: sel[x[1:0]] = d & msk(x[1:0]);
      6'h0b:
        if (x[1:0] == 2'd0 && d[0])
          for (g = 0; g < 4; g = g + 1)
            lat[g] = 8'h0;
      default: ;
    endcase
  endtask

  // set wins: live enabled events relatch after any clear
  task settle;
    reg ea;
    reg eb;
    begin
      repeat (6) @(posedge clk);
      ea = 1'b1;
      eb = 1'b1;
      for (g = 0; g < 4; g = g + 1)
      begin
        lat[g] = (lat[g] | live(g)) & en[g];
        ea = ea & ~|(lat[g] & ~sel[g]);
        eb = eb & ~|(lat[g] & sel[g]);
      end
      chk({30'h0, pa_n, pb_n}, {30'h0, ea, eb});
    end
  endtask

  initial
  begin
    for (g = 0; g < 4; g = g + 1)
    begin
      en[g] = 8'h0;
      sel[g] = 8'h0;
      lat[g] = 8'h0;
    end
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (i = 8'h20; i < 8'h30; i = i + 1)
    begin
      bus(1'b0, i[7:0], 8'h0, 1'b1);
      chk(q, 32'h0);
    end
    // two latched events share pin a; it frees only after both clears
    bus(1'b1, 8'h21, 8'h09, 1'b1);
    mwr(8'h21, 8'h09);
    @(posedge clk);
    ev <= 13'h0060;
    settle;
    @(posedge clk);
    ev <= 13'h0000;
    settle;
    for (i = 0; i < 2; i = i + 1)
    begin
      bus(1'b1, 8'h25, 8'h01 << (3 * i), 1'b1);
      mwr(8'h25, 8'h01 << (3 * i));
      settle;
      chk({31'h0, pa_n}, {31'h0, i[0]});
    end
    for (i = 0; i < 300; i = i + 1)
    begin
      r = $random(seed);
      if (r[5:4] == 2'd0)
      begin
        @(posedge clk);
        ev <= r[18:6];
      end
      else if (r[5:4] == 2'd3)
      begin
        bus(1'b0, 8'h20 + {4'h0, r[3:0]}, 8'h0, r[28]);
        chk(q, {24'h0, exp_rd(8'h20 + {4'h0, r[3:0]})});
      end
      else
      begin
        bus(1'b1, 8'h20 + {4'h0, r[3:0]}, r[27:20], r[28]);
        if (r[28])
          mwr(8'h20 + {4'h0, r[3:0]}, r[27:20]);
      end
      settle;
    end
    for (i = 8'h20; i < 8'h30; i = i + 1)
    begin
      bus(1'b0, i[7:0], 8'h0, 1'b0);
      chk(q, {24'h0, exp_rd(i[7:0])});
    end
    // a reset in mid-run must bring every enable, select and latch back to zero
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (g = 0; g < 4; g = g + 1)
    begin
      en[g] = 8'h0;
      sel[g] = 8'h0;
      lat[g] = 8'h0;
    end
    settle;
    for (i = 8'h20; i < 8'h30; i = i + 1)
    begin
      bus(1'b0, i[7:0], 8'h0, 1'b1);
      chk(q, {24'h0, exp_rd(i[7:0])});
    end
    chk({31'h0, falls_a > 0 && falls_b > 0}, 32'h1);
    test_done;
  end
endmodule
